// >>> verilog/sfb_core.sv
// Serial flash buffer, setup and flag command sequencer
`timescale 1ns/10ps
`include "sfb_regs.svh"
module sfb_core
	import sfb_pkg::*;
#(
	parameter int  XFER_CYCLES = `SFB_XFER_TIME_NS / `SFB_CLK_PERIOD_NS,
	parameter int  PROG_CYCLES = `SFB_PROG_TIME_NS / `SFB_CLK_PERIOD_NS,
	parameter int  INFO_LEN    = 16,
	parameter logic [7:0] INFO_ID = 8'h5a
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe_n,
	input  wire logic       array_busy,
	input  wire logic       write_enable,
	input  wire logic       compare_diff,
	output logic [8:0]      setup_word_field,
	output logic            ready
);
	import sfb_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detect

	logic [2:0] pin_s;
	logic       sck_d_ff;
	logic       cs_d_ff;
	logic       sck_s;
	logic       cs_s;
	logic       si_s;

	sfb_sync #(.W(3)) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.din    ({sck, ~cs_n, si}),
		.dout   (pin_s)
	);

	assign sck_s = pin_s[2];
	// Select travels inverted so that the cleared synchroniser reads deselected
	// and no false select edge follows reset
	assign cs_s  = !pin_s[1];
	assign si_s  = pin_s[0];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_d_ff <= 1'b0;
			cs_d_ff  <= 1'b1;
		end else begin
			sck_d_ff <= sck_s;
			cs_d_ff  <= cs_s;
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	assign sck_rise = sck_s && !sck_d_ff && !cs_s;
	assign sck_fall = !sck_s && sck_d_ff && !cs_s;
	assign cs_fall  = !cs_s && cs_d_ff;
	assign cs_rise  = cs_s && !cs_d_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Serial receive shifter, MSB first

	logic [15:0] shift_ff;
	logic [4:0]  bit_cnt_ff;
	logic [1:0]  field_cnt_ff;
	logic [7:0]  opc_ff;
	logic [8:0]  offset_ff;
	logic [15:0] word_ff;
	sfb_state_t  state_ff;
	sfb_state_t  nxt_state;

	logic byte_done;
	logic word_done;

	assign byte_done = sck_rise && (bit_cnt_ff == 5'd7);
	assign word_done = sck_rise && (bit_cnt_ff == 5'd15);

	////////////////////////////////////////////////////////////////////////////////
	// Command classification

	logic [7:0] opc_now;
	logic       is_copy;
	logic       is_pb_cmd;
	logic       is_stream;
	logic       known_opc;
	logic       blocked;

	assign opc_now   = {shift_ff[6:0], si_s};
	assign is_copy   = (opc_ff == `SFB_OP_XFER_DB_TO_PB) || (opc_ff == `SFB_OP_XFER_PB_TO_DB);
	assign is_pb_cmd = (opc_ff == `SFB_OP_READ_PB) || (opc_ff == `SFB_OP_XFER_PB_TO_DB);
	assign is_stream = (opc_ff == `SFB_OP_READ_PB) || (opc_ff == `SFB_OP_READ_DB)
		|| (opc_ff == `SFB_OP_READ_INFO) || (opc_ff == `SFB_OP_READ_SETUP)
		|| (opc_ff == `SFB_OP_READ_FLAGS);
	assign known_opc = (opc_now == `SFB_OP_XFER_DB_TO_PB) || (opc_now == `SFB_OP_READ_PB)
		|| (opc_now == `SFB_OP_XFER_PB_TO_DB) || (opc_now == `SFB_OP_READ_SETUP)
		|| (opc_now == `SFB_OP_WRITE_SETUP) || (opc_now == `SFB_OP_READ_FLAGS)
		|| (opc_now == `SFB_OP_CLEAR_MISMATCH) || (opc_now == `SFB_OP_READ_INFO)
		|| (opc_now == `SFB_OP_READ_DB);

	logic xfer_busy_flag;
	logic prog_busy;
	logic opc_blocked;

	// Busy array refuses the program buffer read and the copy out of the program buffer; copies lock both buffers
	assign opc_blocked = ((opc_now == `SFB_OP_READ_PB) || (opc_now == `SFB_OP_XFER_PB_TO_DB))
		&& array_busy;
	assign blocked = opc_blocked || (xfer_busy_flag && (opc_now != `SFB_OP_READ_FLAGS)
		&& (opc_now != `SFB_OP_CLEAR_MISMATCH));

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer state

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SFB_IDLE: begin
				if (cs_fall)
					nxt_state = SFB_OPC;
			end
			SFB_OPC: begin
				if (byte_done)
					nxt_state = (known_opc && !blocked) ? SFB_FIELDS : SFB_SINK;
			end
			SFB_FIELDS: begin
				if (word_done && field_cnt_ff == 2'd2)
					nxt_state = is_stream ? SFB_DATA : SFB_SINK;
			end
			SFB_DATA: nxt_state = SFB_DATA;
			SFB_SINK: nxt_state = SFB_SINK;
			default:  nxt_state = SFB_IDLE;
		endcase
		if (cs_rise)
			nxt_state = SFB_IDLE;
	end

	logic framed;
	assign framed = cs_rise && (state_ff == SFB_SINK || state_ff == SFB_DATA)
		&& field_cnt_ff == 2'd3;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			state_ff <= SFB_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Bit, field, opcode and word capture
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shift_ff     <= 16'h0000;
			bit_cnt_ff   <= 5'd0;
			field_cnt_ff <= 2'd0;
			opc_ff       <= 8'h00;
			word_ff      <= 16'h0000;
		end else if (cs_fall) begin
			bit_cnt_ff   <= 5'd0;
			field_cnt_ff <= 2'd0;
			opc_ff       <= 8'h00;
		end else if (sck_rise) begin
			shift_ff <= {shift_ff[14:0], si_s};
			if (state_ff == SFB_OPC) begin
				bit_cnt_ff <= (bit_cnt_ff == 5'd7) ? 5'd0 : bit_cnt_ff + 5'd1;
				if (byte_done)
					opc_ff <= opc_now;
			end else if (state_ff == SFB_FIELDS) begin
				// Wrap per 16-bit field so every field ends on a count of 15
				bit_cnt_ff <= (bit_cnt_ff == 5'd15) ? 5'd0 : bit_cnt_ff + 5'd1;
				if (word_done) begin
					field_cnt_ff <= field_cnt_ff + 2'd1;
					if (field_cnt_ff == 2'd0)
						word_ff <= {shift_ff[14:0], si_s};
					if (field_cnt_ff == 2'd2)
						field_cnt_ff <= 2'd3;
				end
			end else if (state_ff == SFB_SINK && !is_stream) begin
				bit_cnt_ff <= 5'd0;
			end else begin
				bit_cnt_ff <= (bit_cnt_ff == 5'd7) ? 5'd0 : bit_cnt_ff + 5'd1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read stream: busy word, then payload

	logic [4:0] lead_cnt_ff;
	logic       in_lead;
	logic [7:0] buf_rd;
	logic [8:0] nxt_offset;
	logic [7:0] flag_byte_field;
	logic [7:0] info_byte;

	assign in_lead    = (lead_cnt_ff != 5'd16);
	assign nxt_offset = (offset_ff == `SFB_BUF_LAST) ? 9'h000 : offset_ff + 9'h001;

	// Offset counter: loaded from the byte field, stepped per streamed byte
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			offset_ff   <= 9'h000;
			lead_cnt_ff <= 5'd0;
		end else if (state_ff == SFB_FIELDS && word_done && field_cnt_ff == 2'd1) begin
			offset_ff   <= {shift_ff[7:0], si_s};
			lead_cnt_ff <= 5'd0;
		end else if (state_ff == SFB_DATA && sck_rise) begin
			if (in_lead)
				lead_cnt_ff <= lead_cnt_ff + 5'd1;
			else if (bit_cnt_ff == 5'd7)
				offset_ff <= nxt_offset;
		end
	end

	// Information sector: identity byte, valid tags, then non-tag marks
	assign info_byte = (offset_ff == 9'h000) ? INFO_ID
		: (offset_ff < 9'(INFO_LEN)) ? `SFB_SECTOR_TAG : 8'h00;

	logic        mismatch_flag_ff;
	logic [8:0]  setup_ff;
	logic [7:0]  payload;
	logic [15:0] setup_word16;
	logic [7:0]  setup_byte;

	assign flag_byte_field = {ready, xfer_busy_flag, write_enable, mismatch_flag_ff,
		4'h0};

	// Setup read: high byte then low byte of a 16-bit word, reserved bits zero
	assign setup_word16 = {7'h00, setup_ff};
	assign setup_byte   = (offset_ff == 9'h000) ? setup_word16[15:8]
		: (offset_ff == 9'h001) ? setup_word16[7:0] : 8'h00;

	// Payload select per read opcode
	assign payload = (opc_ff == `SFB_OP_READ_FLAGS) ? flag_byte_field
		: (opc_ff == `SFB_OP_READ_INFO) ? info_byte
		: (opc_ff == `SFB_OP_READ_SETUP) ? setup_byte
		: buf_rd;

	// Output shifter: busy word, then payload, one bit per link clock fall
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			so <= 1'b0;
		end else if (state_ff != SFB_DATA) begin
			so <= 1'b0;
		end else if (sck_fall) begin
			if (in_lead)
				so <= !ready; // Busy word: ones while busy
			else
				so <= payload[3'd7 - bit_cnt_ff[2:0]];
		end
	end
	assign so_oe_n = (state_ff != SFB_DATA);

	////////////////////////////////////////////////////////////////////////////////
	// Buffers and copy engine

	logic copy_busy;
	logic copy_go;

	assign copy_go = framed && is_copy && !opc_blocked && !xfer_busy_flag;

	sfb_buf u_buf (
		.clk        (clk),
		.resetn     (resetn),
		.rd_addr    (offset_ff),
		.rd_sel_pb  (is_pb_cmd),
		.rd_data    (buf_rd),
		.wr_en      (1'b0),
		.wr_addr    (9'h000),
		.wr_data    (8'h00),
		.copy_start (copy_go),
		.copy_to_pb (opc_ff == `SFB_OP_XFER_DB_TO_PB),
		.copy_busy  (copy_busy)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Timers, setup word and flags

	logic [31:0] xfer_cnt_ff;
	logic [31:0] prog_cnt_ff;
	logic        setup_go;

	assign setup_go  = framed && (opc_ff == `SFB_OP_WRITE_SETUP);
	assign xfer_busy_flag = (xfer_cnt_ff != 32'd0) || copy_busy;
	assign prog_busy = (prog_cnt_ff != 32'd0);
	assign ready     = !(prog_busy || array_busy || xfer_busy_flag);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			xfer_cnt_ff <= 32'd0;
			prog_cnt_ff <= 32'd0;
		end else begin
			if (copy_go)
				xfer_cnt_ff <= 32'(XFER_CYCLES);
			else if (xfer_cnt_ff != 32'd0)
				xfer_cnt_ff <= xfer_cnt_ff - 32'd1;
			if (setup_go)
				prog_cnt_ff <= 32'(PROG_CYCLES);
			else if (prog_busy)
				prog_cnt_ff <= prog_cnt_ff - 32'd1;
		end
	end

	// Setup word kept in setup_ff, cleared by reset; only the low 9 bits stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			setup_ff <= `SFB_SETUP_RESET;
		else if (setup_go)
			setup_ff <= word_ff[8:0];
	end
	assign setup_word_field = setup_ff;

	// Mismatch flag: a compare difference wins over a clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			mismatch_flag_ff <= 1'b0;
		else if (compare_diff)
			mismatch_flag_ff <= 1'b1;
		else if (cs_rise && opc_ff == `SFB_OP_CLEAR_MISMATCH && field_cnt_ff == 2'd0
			&& state_ff == SFB_FIELDS)
			mismatch_flag_ff <= 1'b0;
	end

endmodule // sfb_core

// >>> verilog/sfb_regs.svh
// Constants of the flash buffer and configuration command sequencer
`ifndef SFB_REGS_SVH
`define SFB_REGS_SVH

// Command opcodes
`define SFB_OP_XFER_DB_TO_PB   8'h92
`define SFB_OP_READ_PB         8'h91
`define SFB_OP_XFER_PB_TO_DB   8'h55
`define SFB_OP_READ_SETUP      8'h8b
`define SFB_OP_WRITE_SETUP     8'h8a
`define SFB_OP_READ_FLAGS      8'h83
`define SFB_OP_CLEAR_MISMATCH  8'h89
`define SFB_OP_READ_INFO       8'h4b
`define SFB_OP_READ_DB         8'h81

// Buffer geometry
`define SFB_BUF_LAST           9'h107
`define SFB_SECTOR_TAG         8'hc9

// Setup word layout
`define SFB_SETUP_USED_W       9
`define SFB_SETUP_RESET        9'h000

// Flag byte bit positions
`define SFB_FLAG_READY         7
`define SFB_FLAG_XFER          6
`define SFB_FLAG_WEN           5
`define SFB_FLAG_MISMATCH      4

// Timing
`define SFB_XFER_TIME_NS       100000
`define SFB_PROG_TIME_NS       5000000
`define SFB_CLK_PERIOD_NS      5

`endif

// >>> verilog/sfb_pkg.sv
// Types of the flash buffer and configuration command sequencer
package sfb_pkg;

	typedef enum logic [2:0] {
		SFB_IDLE   = 3'b000,
		SFB_OPC    = 3'b001,
		SFB_FIELDS = 3'b010,
		SFB_DATA   = 3'b011,
		SFB_SINK   = 3'b100
	} sfb_state_t;

	typedef enum logic [1:0] {
		SFB_JOB_NONE  = 2'b00,
		SFB_JOB_DB_PB = 2'b01,
		SFB_JOB_PB_DB = 2'b10,
		SFB_JOB_SETUP = 2'b11
	} sfb_job_t;

endpackage

// >>> verilog/sfb_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module sfb_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_ff;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			dout    <= '0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end

endmodule // sfb_sync

// >>> verilog/sfb_buf.sv
// Dual 264-byte buffer pair with a whole-buffer copy engine
`timescale 1ns/10ps
`include "sfb_regs.svh"
module sfb_buf #(
	parameter int DEPTH = 264
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [8:0] rd_addr,
	input  wire logic       rd_sel_pb,
	output logic      [7:0] rd_data,
	input  wire logic       wr_en,
	input  wire logic [8:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       copy_start,
	input  wire logic       copy_to_pb,
	output logic            copy_busy
);

	logic [7:0] data_mem [DEPTH];
	logic [7:0] prog_mem [DEPTH];
	logic [8:0] copy_idx_ff;
	logic       copy_dir_ff;
	logic       copy_busy_ff;
	logic [8:0] nxt_copy_idx;
	logic       copy_last;

	assign copy_last    = (copy_idx_ff == `SFB_BUF_LAST);
	assign nxt_copy_idx = copy_last ? 9'h000 : copy_idx_ff + 9'h001;
	assign copy_busy    = copy_busy_ff;

	// Copy engine walks every entry once per request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			copy_idx_ff  <= 9'h000;
			copy_dir_ff  <= 1'b0;
			copy_busy_ff <= 1'b0;
		end else if (copy_start && !copy_busy_ff) begin
			copy_idx_ff  <= 9'h000;
			copy_dir_ff  <= copy_to_pb;
			copy_busy_ff <= 1'b1;
		end else if (copy_busy_ff) begin
			copy_idx_ff  <= nxt_copy_idx;
			copy_busy_ff <= !copy_last;
		end
	end

	// Storage writes: host data goes to the data buffer, copies to either side
	always_ff @(posedge clk) begin
		if (copy_busy_ff && copy_dir_ff)
			prog_mem[copy_idx_ff] <= data_mem[copy_idx_ff];
		if (copy_busy_ff && !copy_dir_ff)
			data_mem[copy_idx_ff] <= prog_mem[copy_idx_ff];
		else if (wr_en)
			data_mem[wr_addr] <= wr_data;
	end

	// Registered read port
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rd_data <= 8'h00;
		else
			rd_data <= rd_sel_pb ? prog_mem[rd_addr] : data_mem[rd_addr];
	end

endmodule // sfb_buf

// >>> bench/sfb_core_sva.sv
// Port checker of the buffer, setup and flag sequencer
`timescale 1ns/10ps
module sfb_core_sva #(
	parameter int XFER_CYCLES = 50,
	parameter int PROG_CYCLES = 100
) (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic       si,
	input wire logic       so,
	input wire logic       so_oe_n,
	input wire logic       array_busy,
	input wire logic       write_enable,
	input wire logic       compare_diff,
	input wire logic [8:0] setup_word_field,
	input wire logic       ready
);
	localparam int LO_MAX = (XFER_CYCLES > PROG_CYCLES ? XFER_CYCLES : PROG_CYCLES) + 1;
	localparam int LO_MIN = (XFER_CYCLES < PROG_CYCLES ? XFER_CYCLES : PROG_CYCLES) - 1;
	logic [31:0] lo_cnt_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	//////////////////////////////////////////////////////////////////////////////
	// Length of the running busy stretch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			lo_cnt_ff <= '0;
		else if (ready || array_busy)
			lo_cnt_ff <= '0;
		else
			lo_cnt_ff <= lo_cnt_ff + 32'h1;
	end
	//////////////////////////////////////////////////////////////////////////////
	oe_idle_a: assert property ($rose(cs_n) |-> ##[0:5] so_oe_n)
		else $error("output on after deselect");
	oe_frame_a: assert property ($fell(so_oe_n) |-> !cs_n && !$past(cs_n, 8))
		else $error("output on outside frame");
	oe_start_a: assert property ($fell(so_oe_n) |-> !so)
		else $error("output enabled with a stale bit");
	so_edge_a: assert property (!so_oe_n && !$past(so_oe_n) && !$stable(so) |-> !sck && !$past(sck, 2))
		else $error("data moved off the falling edge");
	setup_busy_a: assert property (!$stable(setup_word_field) |-> (##[0:4] !ready) or ($past(ready) == 1'b0))
		else $error("setup changed without busy");
	ready_cs_a: assert property ($fell(ready) && !array_busy |-> $past(cs_n, 2))
		else $error("busy began inside a frame");
	busy_max_a: assert property (lo_cnt_ff <= LO_MAX)
		else $error("busy stretch too long");
	busy_min_a: assert property ($rose(ready) && !$past(array_busy) |-> lo_cnt_ff >= LO_MIN)
		else $error("busy stretch too short");
	cover property ($rose(ready));
	cover property ($fell(so_oe_n));
	cover property (!$stable(setup_word_field));
endmodule // sfb_core_sva

bind sfb_core sfb_core_sva #(.XFER_CYCLES(XFER_CYCLES), .PROG_CYCLES(PROG_CYCLES)) chk (
	.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
	.array_busy(array_busy), .write_enable(write_enable), .compare_diff(compare_diff),
	.setup_word_field(setup_word_field), .ready(ready));

// >>> bench/sfb_host.sv
// Host master model driving the serial link
`timescale 1ns/10ps
module sfb_host (
	input  wire logic clk,
	input  wire logic so,
	input  wire logic so_oe_n,
	output logic      sck,
	output logic      cs_n,
	output logic      si
);
	logic oe_low = 1'b0;
	logic cs_n_d = 1'b1;
	// Link idle: clock parked low, deselected
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Notes whether the device drove its output in the current or last frame
	always @(posedge clk) begin
		cs_n_d <= cs_n;
		if (cs_n_d && !cs_n)
			oe_low <= 1'b0;
		else if (!cs_n && !so_oe_n)
			oe_low <= 1'b1;
	end
	//////////////////////////////////////////////////////////////////////////////
	// One link clock of 125 ns, output taken before the rise
	task automatic xbit(input logic b, inout logic [63:0] r);
		si <= b;
		repeat (12) @(posedge clk);
		r = {r[62:0], so};
		sck <= 1'b1;
		repeat (13) @(posedge clk);
		sck <= 1'b0;
	endtask
	// Opcode, nw fields (third on zero), then nrd read bits
	task automatic frame(input logic [7:0] op, input logic [15:0] w0, input logic [15:0] w1,
		input int nw, input int nrd, output logic [63:0] rd);
		logic [63:0] dump;
		logic [15:0] bits;
		rd = '0;
		dump = '0;
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 7; i >= 0; i--) xbit(op[i], dump);
		for (int f = 0; f < nw; f++) begin
			bits = (f == 0) ? w0 : (f == 1) ? w1 : 16'h0000;
			for (int i = 15; i >= 0; i--) xbit(bits[i], dump);
		end
		for (int i = 0; i < nrd; i++) xbit(1'b0, rd);
		repeat (12) @(posedge clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (40) @(posedge clk);
	endtask
endmodule // sfb_host

// >>> bench/sfb_core_bench.sv
// Self-checking bench of the buffer, setup and flag sequencer
`timescale 1ns/10ps
module sfb_core_bench;
	import sfb_pkg::*;
	localparam int XFER = 5000;
	localparam int PROG = 3000;
	logic        clk, resetn, sck, cs_n, si, so, so_oe_n, ready;
	logic        array_busy, write_enable, compare_diff;
	logic [8:0]  setup_word_field;
	logic [63:0] rd;
	int          bad_count = 0;
	int          total_checks = 0;
	//////////////////////////////////////////////////////////////////////////////
	sfb_core #(.XFER_CYCLES(XFER), .PROG_CYCLES(PROG)) uut (
		.clk(clk), .resetn(resetn), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n),
		.array_busy(array_busy), .write_enable(write_enable), .compare_diff(compare_diff),
		.setup_word_field(setup_word_field), .ready(ready));
	sfb_host host (.clk(clk), .so(so), .so_oe_n(so_oe_n), .sck(sck), .cs_n(cs_n), .si(si));
	// 200 MHz clock
	always #2.5 clk = ~clk;
	//////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Bounded wait for the device to go idle
	task automatic wait_ready;
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (ready !== 1'b1) begin
			bad_count++;
			$display("FAIL at %0t: ready never returned", $time);
			test_done;
		end
	endtask
	task automatic flags;
		host.frame(8'h83, 16'h0000, 16'h0000, 3, 24, rd);
	endtask
	//////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		array_busy = 1'b0;
		write_enable = 1'b0;
		compare_diff = 1'b0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check(setup_word_field, 9'h000);
		check({ready, so_oe_n}, 2'b11);
		write_enable <= 1'b1;
		flags;
		check(rd[23:4], 20'h0000a);
		compare_diff <= 1'b1;
		@(posedge clk);
		compare_diff <= 1'b0;
		flags;
		check(rd[23:4], 20'h0000b);
		host.frame(8'h89, 16'h0000, 16'h0000, 0, 0, rd);
		flags;
		check(rd[23:4], 20'h0000a);
		// Setup read before write, write, busy, read back, aborted write
		host.frame(8'h8b, 16'h0000, 16'h0000, 3, 32, rd);
		check(rd[31:0], 32'h00000000);
		host.frame(8'h8a, 16'h01a5, 16'h0000, 3, 0, rd);
		flags;
		check(rd[23:7], 17'h1fffe);
		wait_ready;
		check(setup_word_field, 9'h1a5);
		host.frame(8'h8b, 16'h0000, 16'h0000, 3, 32, rd);
		check(rd[31:0], 32'h000001a5);
		host.frame(8'h8a, 16'h0042, 16'h0000, 1, 0, rd);
		check({ready, setup_word_field}, 10'h3a5);
		// Information sector from zero and across the wrap
		host.frame(8'h4b, 16'h0000, 16'h0000, 3, 40, rd);
		check(rd[39:0], {16'h0000, 8'h5a, 16'hc9c9});
		host.frame(8'h4b, 16'h0000, 16'h0107, 3, 32, rd);
		check(rd[31:0], 32'h0000005a);
		// Copy into the program buffer refuses program buffer reads until done
		host.frame(8'h92, 16'h0000, 16'h0000, 3, 0, rd);
		flags;
		check(rd[6], 1'b1);
		host.frame(8'h91, 16'h0000, 16'h0000, 3, 24, rd);
		check(host.oe_low, 1'b0);
		wait_ready;
		repeat (XFER) @(posedge clk);
		flags;
		check(rd[6], 1'b0);
		host.frame(8'h91, 16'h0000, 16'h0000, 3, 24, rd);
		check({host.oe_low, rd[23:8]}, 17'h10000);
		// Array programming refuses both program buffer commands
		array_busy <= 1'b1;
		write_enable <= 1'b0;
		host.frame(8'h55, 16'h0000, 16'h0000, 3, 0, rd);
		host.frame(8'h91, 16'h0000, 16'h0000, 3, 24, rd);
		check(host.oe_low, 1'b0);
		flags;
		check(rd[7:4], 4'h0);
		array_busy <= 1'b0;
		repeat (4) @(posedge clk);
		host.frame(8'h55, 16'h0000, 16'h0000, 3, 0, rd);
		flags;
		check(rd[6], 1'b1);
		wait_ready;
		repeat (XFER) @(posedge clk);
		test_done;
	end
endmodule // sfb_core_bench
